// ---- include/rcs_pkg.sv ----
/*
 Package for the remote calibration sequencer: command codes, step range,
 adjust limits, value width and reset values.
 Assumes a decoded command arrives from a parser ahead of this block.
*/
package rcs_pkg;
   localparam int VAL_W = 16;
   localparam int STEP_W = 6;
   localparam int ARG_W = 16;
   localparam int PWD_W = 16;
   localparam logic [STEP_W-1:0] STEP_FIRST = 6'h03;
   localparam logic [STEP_W-1:0] STEP_LAST = 6'h37;
   localparam int NUM_STEPS = 56;
   localparam logic signed [ARG_W-1:0] ADJ_MIN = -16'sd100;
   localparam logic signed [ARG_W-1:0] ADJ_MAX = 16'sd100;
   localparam logic [PWD_W-1:0] PWD_NONE = 16'h0000;
   localparam logic [VAL_W-1:0] VAL_RESET = 16'h0000;

   typedef enum logic [2:0] {
      RCS_CMD_NONE,
      RCS_CMD_START,
      RCS_CMD_SAVE,
      RCS_CMD_ABORT,
      RCS_CMD_ADJUST,
      RCS_CMD_ADVANCE
   } rcs_cmd_t;

   typedef enum logic [1:0] {
      RCS_IDLE,
      RCS_CAL,
      RCS_COMMIT,
      RCS_RESTORE
   } rcs_state_t;
endpackage : rcs_pkg

// ---- include/rcs_mem_if.sv ----
/*
 Interface between the sequencer and its dual value memory.
 Assumes one clock shared by both ends.
*/
`timescale 1ns/1ps
`default_nettype none
interface rcs_mem_if;
   import rcs_pkg::*;
   logic [STEP_W-1:0] addr;
   logic              wr_work;
   logic              wr_store;
   logic [VAL_W-1:0]  wdata;
   logic              sel_store;
   logic [VAL_W-1:0]  rdata;
   modport seq (output addr, wr_work, wr_store, wdata, sel_store,
                input rdata);
   modport mem (input addr, wr_work, wr_store, wdata, sel_store,
                output rdata);
endinterface : rcs_mem_if
`default_nettype wire

// ---- logic/rcs_value_mem.sv ----
/*
 Working and stored calibration value memories with registered read.
 Assumes the sequencer drives one access per cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module rcs_value_mem
   import rcs_pkg::*;
(
   input  wire logic ref_clk,
   rcs_mem_if.mem    mem
);
   // Power-on contents start at the reset value
   logic [VAL_W-1:0] work_mem  [NUM_STEPS] = '{default: VAL_RESET};
   logic [VAL_W-1:0] store_mem [NUM_STEPS] = '{default: VAL_RESET};
   logic [VAL_W-1:0] rdata_reg;

   always_ff @(posedge ref_clk) begin
      if (mem.wr_work) begin
         work_mem[mem.addr] <= mem.wdata;
      end
      if (mem.wr_store) begin
         store_mem[mem.addr] <= mem.wdata;
      end
      rdata_reg <= mem.sel_store ? store_mem[mem.addr] : work_mem[mem.addr];
   end

   assign mem.rdata = rdata_reg;
endmodule : rcs_value_mem
`default_nettype wire

// ---- logic/rcs_sequencer.sv ----
/*
 Remote calibration sequencer: calibration mode, password check, adjust,
 advance, save and abort of per-step calibration values.
 Assumes commands are decoded upstream from serial or GPIB and arrive as
 one-cycle strobes; the password is owned by the local keyboard path.
*/
`timescale 1ns/1ps
`default_nettype none
module rcs_sequencer
   import rcs_pkg::*;
(
   input  wire logic                  ref_clk,
   input  wire logic                  rstn,
   input  wire logic                  ser_cmd_valid,
   input  wire rcs_pkg::rcs_cmd_t     ser_cmd,
   input  wire logic [rcs_pkg::ARG_W-1:0] ser_arg,
   input  wire logic                  gpib_cmd_valid,
   input  wire rcs_pkg::rcs_cmd_t     gpib_cmd,
   input  wire logic [rcs_pkg::ARG_W-1:0] gpib_arg,
   input  wire logic [rcs_pkg::PWD_W-1:0] local_password,
   output logic                       cal_mode,
   output logic                       cal_busy,
   output logic [rcs_pkg::STEP_W-1:0] cal_step,
   output logic [rcs_pkg::VAL_W-1:0]  cal_value,
   output logic                       cal_start_denied
);
   import rcs_pkg::*;

   rcs_mem_if mif ();

   rcs_value_mem u_mem (
      .ref_clk (ref_clk),
      .mem     (mif)
   );

   // ----------------------------------------------------------------
   // Command merge
   // ----------------------------------------------------------------
   logic                    cmd_valid;
   rcs_cmd_t                cmd;
   logic signed [ARG_W-1:0] arg;

   always_comb begin
      // Serial and GPIB feed one decoder; serial wins a same-cycle tie
      cmd_valid = ser_cmd_valid | gpib_cmd_valid;
      cmd       = ser_cmd_valid ? ser_cmd : gpib_cmd;
      arg       = ser_cmd_valid ? ser_arg : gpib_arg;
   end

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   rcs_state_t        state_reg, state_next;
   logic [STEP_W-1:0] step_reg, step_next;
   logic [STEP_W-1:0] walk_reg, walk_next;
   logic [VAL_W-1:0]  value_reg, value_next;
   logic              denied_reg, denied_next;
   logic              phase_reg, phase_next;
   logic              undo_reg, undo_next;
   logic              pwd_ok;
   logic              adj_ok;
   logic signed [ARG_W-1:0] sval;

   // Password is an input only: no command writes it
   assign pwd_ok = (local_password == PWD_NONE) ||
                   (arg == local_password);
   assign adj_ok = (arg >= ADJ_MIN) && (arg <= ADJ_MAX);
   assign sval   = $signed(value_reg);

   always_comb begin
      state_next    = state_reg;
      step_next     = step_reg;
      walk_next     = walk_reg;
      value_next    = value_reg;
      denied_next   = 1'b0;
      phase_next    = 1'b0;
      undo_next     = undo_reg;
      mif.addr      = step_reg;
      mif.wr_work   = 1'b0;
      mif.wr_store  = 1'b0;
      mif.wdata     = value_reg;
      mif.sel_store = 1'b0;
      case (state_reg)
         RCS_IDLE: begin
            if (cmd_valid && cmd == RCS_CMD_START) begin
               if (pwd_ok) begin
                  // First value comes through the registered read path
                  state_next = RCS_RESTORE;
                  step_next  = STEP_FIRST;
                  walk_next  = STEP_FIRST;
                  undo_next  = 1'b0;
               end else begin
                  denied_next = 1'b1;
               end
            end
         end
         RCS_CAL: begin
            if (cmd_valid) begin
               case (cmd)
                  RCS_CMD_ADJUST: begin
                     if (adj_ok) begin
                        value_next = VAL_W'(sval + arg);
                     end
                  end
                  RCS_CMD_ADVANCE: begin
                     mif.wr_work = 1'b1;
                     if (step_reg != STEP_LAST) begin
                        step_next = step_reg + 6'h01;
                     end
                     state_next = RCS_RESTORE;
                     walk_next  = step_next;
                  end
                  RCS_CMD_SAVE: begin
                     mif.wr_work = 1'b1;
                     state_next  = RCS_COMMIT;
                     walk_next   = STEP_FIRST;
                  end
                  RCS_CMD_ABORT: begin
                     state_next = RCS_RESTORE;
                     walk_next  = STEP_FIRST;
                     undo_next  = 1'b1;
                  end
                  default: begin
                  end
               endcase
            end
         end
         RCS_COMMIT: begin
            // Working set into stored set: read phase, then write phase,
            // since read data lag the address by one cycle
            mif.addr   = walk_reg;
            phase_next = !phase_reg;
            if (phase_reg) begin
               mif.wr_store = 1'b1;
               mif.wdata    = mif.rdata;
               walk_next    = walk_reg + 6'h01;
               if (walk_reg == STEP_LAST) begin
                  state_next = RCS_IDLE;
               end
            end
         end
         RCS_RESTORE: begin
            // After abort: stored set back into working set, two cycles
            // a word; otherwise reload the selected step's value
            mif.addr      = walk_reg;
            mif.sel_store = undo_reg;
            phase_next    = !phase_reg;
            if (phase_reg && undo_reg) begin
               mif.wr_work = 1'b1;
               mif.wdata   = mif.rdata;
               walk_next   = walk_reg + 6'h01;
               if (walk_reg == STEP_LAST) begin
                  state_next = RCS_IDLE;
               end
            end else if (phase_reg) begin
               state_next = RCS_CAL;
               value_next = mif.rdata;
            end
         end
         default: begin
            state_next = RCS_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         state_reg  <= RCS_IDLE;
         step_reg   <= STEP_FIRST;
         walk_reg   <= STEP_FIRST;
         value_reg  <= VAL_RESET;
         denied_reg <= 1'b0;
         phase_reg  <= 1'b0;
         undo_reg   <= 1'b0;
      end else begin
         state_reg  <= state_next;
         step_reg   <= step_next;
         walk_reg   <= walk_next;
         value_reg  <= value_next;
         denied_reg <= denied_next;
         phase_reg  <= phase_next;
         undo_reg   <= undo_next;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   logic mode_reg, busy_reg;
   logic [STEP_W-1:0] step_out_reg;
   logic [VAL_W-1:0]  val_out_reg;

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         mode_reg     <= 1'b0;
         busy_reg     <= 1'b0;
         step_out_reg <= STEP_FIRST;
         val_out_reg  <= VAL_RESET;
      end else begin
         mode_reg     <= (state_next != RCS_IDLE);
         busy_reg     <= (state_next == RCS_COMMIT) ||
                         (state_next == RCS_RESTORE);
         step_out_reg <= step_next;
         val_out_reg  <= value_next;
      end
   end

   assign cal_mode         = mode_reg;
   assign cal_busy         = busy_reg;
   assign cal_step         = step_out_reg;
   assign cal_value        = val_out_reg;
   assign cal_start_denied = denied_reg;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   AST_IDLE_IGNORES: assert property (@(posedge ref_clk) disable iff (!rstn)
      state_reg == RCS_IDLE && !(cmd_valid && cmd == RCS_CMD_START)
      |=> state_reg == RCS_IDLE)
      else $error("command acted on outside calibration");
   AST_PWD_DENY: assert property (@(posedge ref_clk) disable iff (!rstn)
      state_reg == RCS_IDLE && cmd_valid && cmd == RCS_CMD_START &&
      local_password != PWD_NONE && arg != local_password
      |=> state_reg == RCS_IDLE && cal_start_denied)
      else $error("start accepted with wrong password");
   AST_NO_PWD: assert property (@(posedge ref_clk) disable iff (!rstn)
      state_reg == RCS_IDLE && cmd_valid && cmd == RCS_CMD_START &&
      local_password == PWD_NONE
      |=> state_reg == RCS_RESTORE && step_reg == STEP_FIRST && cal_mode)
      else $error("start refused without password");
   AST_ADJ_ADD: assert property (@(posedge ref_clk) disable iff (!rstn)
      state_reg == RCS_CAL && cmd_valid && cmd == RCS_CMD_ADJUST && adj_ok
      |=> value_reg == VAL_W'($signed($past(value_reg)) + $past(arg)))
      else $error("adjust sum wrong");
   AST_ADJ_RANGE: assert property (@(posedge ref_clk) disable iff (!rstn)
      state_reg == RCS_CAL && cmd_valid && cmd == RCS_CMD_ADJUST && !adj_ok
      |=> $stable(value_reg))
      else $error("out of range adjust applied");
   AST_ADVANCE: assert property (@(posedge ref_clk) disable iff (!rstn)
      state_reg == RCS_CAL && cmd_valid && cmd == RCS_CMD_ADVANCE &&
      step_reg != STEP_LAST
      |-> mif.wr_work ##1 step_reg == $past(step_reg) + 6'h01)
      else $error("advance did not store and step");
   AST_SAVE: assert property (@(posedge ref_clk) disable iff (!rstn)
      state_reg == RCS_CAL && cmd_valid && cmd == RCS_CMD_SAVE
      |=> state_reg == RCS_COMMIT ##[100:110] state_reg == RCS_IDLE)
      else $error("save did not finish");
   AST_ABORT: assert property (@(posedge ref_clk) disable iff (!rstn)
      state_reg == RCS_CAL && cmd_valid && cmd == RCS_CMD_ABORT
      |=> !mif.wr_store throughout (##[1:120] state_reg == RCS_IDLE))
      else $error("abort stored values");
endmodule : rcs_sequencer
`default_nettype wire

// ---- testbench/rcs_ctrl_model.sv ----
/*
 Remote controller model: drives one command port of the sequencer.
 Assumes send is called just after a rising edge of ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module rcs_ctrl_model
   import rcs_pkg::*;
(
   input  wire logic                 ref_clk,
   output logic                      cmd_valid,
   output rcs_pkg::rcs_cmd_t         cmd,
   output logic [rcs_pkg::ARG_W-1:0] arg
);
   initial begin
      cmd_valid = 1'b0;
      cmd       = RCS_CMD_NONE;
      arg       = 16'h0000;
   end

   // One strobe; a released argument shows the inverse, never the old value
   task automatic send(input rcs_cmd_t c, input logic [ARG_W-1:0] a);
      cmd_valid = 1'b1;
      cmd       = c;
      arg       = a;
      @(posedge ref_clk);
      #1;
      cmd_valid = 1'b0;
      cmd       = RCS_CMD_NONE;
      arg       = ~a;
   endtask : send
endmodule : rcs_ctrl_model
`default_nettype wire

// ---- testbench/tb_top.sv ----
/*
 Self-checking bench: random calibration sessions over both ports.
 Assumes the controller model rcs_ctrl_model on each command port.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import rcs_pkg::*;
   logic              ref_clk = 1'b0;
   logic              rstn = 1'b0;
   logic [PWD_W-1:0]  local_password = 16'h0000;
   logic              s_v, g_v, cal_mode, cal_busy, cal_start_denied;
   rcs_cmd_t          s_c, g_c;
   logic [ARG_W-1:0]  s_a, g_a;
   logic [STEP_W-1:0] cal_step;
   logic [VAL_W-1:0]  cal_value;
   logic [VAL_W-1:0]  work [NUM_STEPS] = '{default: VAL_RESET};
   logic [VAL_W-1:0]  stored [NUM_STEPS] = '{default: VAL_RESET};
   logic [31:0]       seed = 32'h0000CE91;
   logic              e_mode = 1'b0;
   logic [STEP_W-1:0] e_step = 6'h03;
   int                error_cnt = 0;
   int                n_tests = 0;
   int                cyc = 0;

   always #12.5 ref_clk = ~ref_clk;

   rcs_sequencer dut (.ref_clk(ref_clk), .rstn(rstn), .ser_cmd_valid(s_v),
      .ser_cmd(s_c), .ser_arg(s_a), .gpib_cmd_valid(g_v), .gpib_cmd(g_c),
      .gpib_arg(g_a), .local_password(local_password), .cal_mode(cal_mode),
      .cal_busy(cal_busy), .cal_step(cal_step), .cal_value(cal_value),
      .cal_start_denied(cal_start_denied));
   rcs_ctrl_model ser_m (.ref_clk(ref_clk), .cmd_valid(s_v), .cmd(s_c),
      .arg(s_a));
   rcs_ctrl_model gpib_m (.ref_clk(ref_clk), .cmd_valid(g_v), .cmd(g_c),
      .arg(g_a));

   // ------------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------------
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd

   // Mostly in range, with both limits and one step past each
   function automatic logic [15:0] adj_arg();
      logic [31:0] r;
      r = rnd();
      case (r[3:0])
         4'h0: return 16'h0064;
         4'h1: return 16'hFF9C;
         4'h2: return 16'h0065;
         4'h3: return 16'hFF9B;
         default: return 16'(r % 201) - 16'h0064;
      endcase
   endfunction : adj_arg

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic end_sim();
      $display("checks=%0d mismatches=%0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : end_sim

   // Sends one command, updates the expected state and compares
   task automatic cmd(input rcs_cmd_t c, input logic [ARG_W-1:0] a);
      logic den;
      int   k;
      den = c == RCS_CMD_START && !e_mode && local_password != PWD_NONE
            && a != local_password;
      if (c == RCS_CMD_START && !e_mode && !den) begin
         e_mode = 1'b1;
         e_step = STEP_FIRST;
      end else if (e_mode && c == RCS_CMD_ADJUST && $signed(a) >= ADJ_MIN
                   && $signed(a) <= ADJ_MAX) begin
         work[e_step] = work[e_step] + a;
      end else if (e_mode && c == RCS_CMD_ADVANCE && e_step != STEP_LAST) begin
         e_step = e_step + 6'h01;
      end else if (e_mode && c == RCS_CMD_SAVE) begin
         stored = work;
      end else if (e_mode && c == RCS_CMD_ABORT) begin
         work = stored;
      end
      if (rnd() & 32'h1) ser_m.send(c, a);
      else gpib_m.send(c, a);
      chk(16'(cal_start_denied), 16'(den));
      if (e_mode && c == RCS_CMD_ADVANCE) chk(16'(cal_busy), 16'h0001);
      @(posedge ref_clk);
      #1;
      k = 0;
      while (cal_busy !== 1'b0 && k < 200) begin
         @(posedge ref_clk);
         #1;
         k++;
      end
      chk(16'(k == 200), 16'h0000);
      if (c == RCS_CMD_SAVE || c == RCS_CMD_ABORT) e_mode = 1'b0;
      chk(16'(cal_mode), 16'(e_mode));
      if (e_mode) begin
         chk(16'(cal_step), 16'(e_step));
         if (!$isunknown(work[e_step])) chk(cal_value, work[e_step]);
      end
   endtask : cmd

   // ------------------------------------------------------------------
   // Run control
   // ------------------------------------------------------------------
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         error_cnt++;
         end_sim();
      end
   end

   initial begin
      int n;
      repeat (2) @(posedge ref_clk);
      #1;
      rstn = 1'b1;
      chk(16'(cal_step), 16'(STEP_FIRST));
      chk(16'(cal_mode), 16'h0000);
      for (int c = 2; c < 6; c++) cmd(rcs_cmd_t'(c), 16'(rnd()));
      for (n = 0; n < 6; n++) begin
         local_password = (n % 2) ? 16'(rnd()) : PWD_NONE;
         cmd(RCS_CMD_START, local_password ^ 16'h0001);
         cmd(RCS_CMD_START, local_password);
         cmd(RCS_CMD_START, 16'h0000);
         repeat (200) begin
            cmd(rnd() % 2 ? RCS_CMD_ADVANCE : RCS_CMD_ADJUST, adj_arg());
         end
         cmd(n % 3 == 1 ? RCS_CMD_ABORT : RCS_CMD_SAVE, 16'(rnd()));
      end
      end_sim();
   end
endmodule : tb_top
`default_nettype wire
